// ==== test/oph_pipe_model.sv ====
// Frame pipeline model supplying per-frame counters and timestamps.
`timescale 1ns/1ps
`default_nettype none
module oph_pipe_model (
  // Clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  // Counters and timestamps for the frame now offered
  output var  logic [31:0] rx_cnt_o,
  output var  logic [31:0] tx_cnt_o,
  output var  logic [31:0] rx_ts_o,
  output var  logic [31:0] tx_ts_o
);
  // All four move every cycle, so a sample taken a cycle late never matches.
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      rx_cnt_o <= 32'h00000100;
      tx_cnt_o <= 32'h00002000;
      rx_ts_o  <= 32'h00030000;
      tx_ts_o  <= 32'h00400000;
    end else begin
      rx_cnt_o <= rx_cnt_o + 32'h00000003;
      tx_cnt_o <= tx_cnt_o + 32'h00000005;
      rx_ts_o  <= rx_ts_o + 32'h00000007;
      tx_ts_o  <= tx_ts_o + 32'h0000000b;
    end
  end
endmodule // oph_pipe_model
`default_nettype wire

// ==== test/oph_responder_props.sv ====
// Checker for the OAM PDU hardware responder ports.
`timescale 1ns/1ps
`default_nettype none
`include "oph_consts.vh"
module oph_responder_props (
  // Clock, reset and register port
  input wire logic        mclk_i,
  input wire logic        rst_n_i,
  input wire logic [7:0]  reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  // Frame in and out
  input wire logic        frm_valid_i,
  input wire logic        frm_tx_dir_i,
  input wire logic [7:0]  frm_opcode_i,
  input wire logic [47:0] frm_smac_i,
  input wire logic        frm_ccm_valid_i,
  input wire logic [31:0] perf_rx_cnt_i,
  input wire logic [31:0] tx_timestamp_i,
  input wire logic [1:0]  out_action_o,
  input wire logic [7:0]  out_opcode_o,
  input wire logic [47:0] out_dmac_o,
  input wire logic [47:0] out_smac_o,
  input wire logic [3:0]  out_cpu_queue_o,
  input wire logic [31:0] out_field_b_o,
  input wire logic [31:0] header_rewrite_value_o,
  input wire logic        header_rewrite_valid_o,
  input wire logic        transid_check_o,
  input wire logic        continuity_miss_clear_o
);
  logic [8:0]  ctl_q;
  logic [1:0]  lsel_q;
  logic [47:0] mac_q;
  logic [15:0] que_q;
  logic        go;
  // Shadow copies of the configuration, kept from observed writes only.
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      ctl_q  <= 9'h000;
      lsel_q <= 2'h3;
      mac_q  <= 48'h0;
      que_q  <= 16'h0;
    end else if (reg_wr_i) begin
      if (reg_addr_i == `OPH_ADDR_HW_CTRL) ctl_q <= reg_wdata_i[8:0];
      if (reg_addr_i == `OPH_ADDR_LOOP_SEL) lsel_q <= reg_wdata_i[1:0];
      if (reg_addr_i == `OPH_ADDR_MAC_LOW) mac_q[31:0] <= reg_wdata_i;
      if (reg_addr_i == `OPH_ADDR_MAC_HIGH) mac_q[47:32] <= reg_wdata_i[15:0];
      if (reg_addr_i == `OPH_ADDR_CPU_QUEUE) que_q <= reg_wdata_i[15:0];
    end
  end
  assign go = frm_valid_i && !reg_wr_i;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  chk_lmm_loop_swap: assert property (
    go && frm_opcode_i == `OPH_OP_LMM && ctl_q[8] && lsel_q[1] |=>
    out_action_o == `OPH_ACT_LOOP && out_opcode_o == `OPH_OP_LMR &&
    out_dmac_o == $past(frm_smac_i) && out_smac_o == mac_q)
    else $error("looped loss request rewritten wrongly");
  chk_lmm_cpu_queue: assert property (
    go && frm_opcode_i == `OPH_OP_LMM && ctl_q[8] && !lsel_q[1] |=>
    out_action_o == `OPH_ACT_CPU && out_cpu_queue_o == que_q[3:0])
    else $error("loss request not sent to its queue");
  chk_lbm_loop_swap: assert property (
    go && frm_opcode_i == `OPH_OP_LBM && ctl_q[6] |=>
    out_opcode_o == `OPH_OP_LBR && out_smac_o == mac_q)
    else $error("looped loopback request rewritten wrongly");
  chk_dmm_loop_stamp: assert property (
    go && frm_opcode_i == `OPH_OP_DMM && ctl_q[4] && lsel_q[0] |=>
    out_opcode_o == `OPH_OP_DMR && out_field_b_o == $past(tx_timestamp_i))
    else $error("looped delay request rewritten wrongly");
  chk_lmr_rewrite_val: assert property (
    go && frm_opcode_i == `OPH_OP_LMR && ctl_q[7] |=>
    header_rewrite_valid_o && header_rewrite_value_o == $past(perf_rx_cnt_i)
    && out_cpu_queue_o == que_q[7:4])
    else $error("loss reply header value wrong");
  chk_idle_pass_through: assert property (
    go && ctl_q == 9'h000 |=> out_action_o == `OPH_ACT_PASS &&
    out_opcode_o == $past(frm_opcode_i) && !transid_check_o)
    else $error("unhandled frame modified");
  chk_ccm_clear_cause: assert property (
    continuity_miss_clear_o |-> $past(frm_valid_i && frm_ccm_valid_i &&
    frm_opcode_i == `OPH_OP_CCM && ctl_q[1]))
    else $error("miss clear without valid handled continuity check");
  chk_tid_rx_only: assert property (
    transid_check_o |-> $past(frm_valid_i) && !$past(frm_tx_dir_i))
    else $error("id check outside received frame");
  chk_ctrl_read_back: assert property (
    reg_rd_i && !reg_wr_i && reg_addr_i == `OPH_ADDR_HW_CTRL |=>
    reg_rdata_o == {23'h0, ctl_q})
    else $error("enable register read back wrong");
endmodule // oph_responder_props
bind oph_responder oph_responder_props u_props (.mclk_i, .rst_n_i,
  .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
  .frm_valid_i, .frm_tx_dir_i, .frm_opcode_i, .frm_smac_i,
  .frm_ccm_valid_i, .perf_rx_cnt_i, .tx_timestamp_i, .out_action_o,
  .out_opcode_o, .out_dmac_o, .out_smac_o, .out_cpu_queue_o,
  .out_field_b_o, .header_rewrite_value_o, .header_rewrite_valid_o,
  .transid_check_o, .continuity_miss_clear_o);
`default_nettype wire

// ==== test/oph_responder_tb.sv ====
// Self-checking testbench for the OAM PDU hardware responder.
`timescale 1ns/1ps
`default_nettype none
`include "oph_consts.vh"
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin \
  error_cnt++; $display("CHECK FAILED %s exp %0h got %0h", n, e, s); end end
module oph_responder_tb;
  logic mclk_i = 0, rst_n_i = 0, reg_wr_i = 0, reg_rd_i = 0;
  logic [7:0] reg_addr_i = 0, frm_opcode_i = 0, mask_i = 0;
  logic [31:0] reg_wdata_i = 0, rdata, rc, tc, rt, tt;
  logic frm_valid_i = 0, frm_tx_dir_i = 0, ccmv_i = 0;
  logic [47:0] frm_dmac_i = 0, frm_smac_i = 0, dm, sm, mac;
  logic [1:0] act, e_act, ls;
  logic [7:0] e_op, opt_tbl [10];
  logic [3:0] q;
  logic [31:0] e_a, e_b, e_h;
  logic [8:0] ctl;
  logic [15:0] qs;
  logic [1:0] opt;
  logic aw, bw, hv, ext, tid, clr, pv, pdir, pcv;
  logic [7:0] pop, pmsk;
  logic [47:0] pdm, psm;
  logic [31:0] prc, ptc, prt, ptt;
  logic [31:0] cc_rx = 0, cc_tx = 0;
  logic [7:0] hcnt = 0;
  int error_cnt = 0, check_count = 0;
  initial forever #5 mclk_i = ~mclk_i;
  oph_pipe_model u_pipe (.mclk_i, .rst_n_i, .rx_cnt_o(rc), .tx_cnt_o(tc),
    .rx_ts_o(rt), .tx_ts_o(tt));
  oph_responder dut (.mclk_i, .rst_n_i, .reg_addr_i, .reg_wdata_i,
    .reg_wr_i, .reg_rd_i, .reg_rdata_o(rdata), .frm_valid_i, .frm_tx_dir_i,
    .frm_opcode_i, .frm_dmac_i, .frm_smac_i,
    .generic_opcode_forward_mask_i(mask_i), .frm_ccm_valid_i(ccmv_i),
    .perf_rx_cnt_i(rc), .perf_tx_cnt_i(tc), .rx_timestamp_i(rt),
    .tx_timestamp_i(tt), .out_valid_o(), .out_action_o(act), .out_opcode_o(),
    .out_dmac_o(), .out_smac_o(), .out_cpu_queue_o(), .out_field_a_o(),
    .out_field_a_wr_o(), .out_field_b_o(), .out_field_b_wr_o(),
    .header_rewrite_value_o(), .header_rewrite_valid_o(),
    .out_pdu_extend_o(), .transid_check_o(), .continuity_miss_clear_o());
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    reg_addr_i <= a; reg_wdata_i <= d; reg_wr_i <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk_i);
    reg_addr_i <= a; reg_rd_i <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    #1 `CHK("rdata", e, rdata)
  endtask
  // Expected handling of the frame taken at the last edge.
  task automatic calc;
    e_act = `OPH_ACT_PASS; e_op = pop; dm = pdm; sm = psm; q = 0;
    {aw, bw, hv, ext, tid, clr} = 6'h0; e_a = 0; e_b = 0; e_h = 0;
    case (pop)
      `OPH_OP_LMM, `OPH_OP_DMM: if (ctl[pop == `OPH_OP_LMM ? 8 : 4]) begin
        aw = 1; e_a = pop == `OPH_OP_LMM ? prc : prt;
        if (ls[pop == `OPH_OP_LMM]) begin
          e_act = `OPH_ACT_LOOP; e_op = pop - 8'h01; dm = psm; sm = mac;
          bw = 1; e_b = pop == `OPH_OP_LMM ? ptc : ptt;
        end else begin
          e_act = `OPH_ACT_CPU; q = pop == `OPH_OP_LMM ? qs[3:0] : qs[11:8];
        end
      end
      `OPH_OP_LMR: if (ctl[7]) begin
        e_act = `OPH_ACT_CPU; q = qs[7:4]; hv = 1; e_h = prc; ext = opt[0];
      end
      `OPH_OP_LBM: if (ctl[6]) begin
        e_act = `OPH_ACT_LOOP; e_op = `OPH_OP_LBR; dm = psm; sm = mac;
      end
      `OPH_OP_LBR: if (ctl[5] && !pdir) begin
        e_act = `OPH_ACT_CHECK; tid = 1;
      end
      `OPH_OP_DMR, `OPH_OP_SDM: if (ctl[pop == `OPH_OP_DMR ? 3 : 2]) begin
        e_act = `OPH_ACT_CPU; q = qs[15:12]; bw = 1; e_b = prt;
      end
      `OPH_OP_CCM: if (ctl[1]) begin
        e_act = `OPH_ACT_CHECK; clr = pcv;
        if (ctl[0] && pcv) begin hv = 1; e_h = prc; aw = opt[1]; e_a = prc;
          cc_rx = prc; cc_tx = ptc; end
      end
      `OPH_OP_TST: if (pmsk[6] && ctl[pdir ? 6 : 5]) begin
        e_act = `OPH_ACT_CHECK; tid = !pdir;
      end
      default: ;
    endcase
  endtask
  task automatic cmp;
    calc();
    if (e_act != `OPH_ACT_PASS) hcnt++;
    `CHK("valid", 1'b1, dut.out_valid_o)
    `CHK("action", e_act, act)
    `CHK("opcode", e_op, dut.out_opcode_o)
    `CHK("dmac", dm, dut.out_dmac_o)
    `CHK("smac", sm, dut.out_smac_o)
    `CHK("queue", q, dut.out_cpu_queue_o)
    `CHK("a_wr", aw, dut.out_field_a_wr_o)
    if (aw) `CHK("field_a", e_a, dut.out_field_a_o)
    `CHK("b_wr", bw, dut.out_field_b_wr_o)
    if (bw) `CHK("field_b", e_b, dut.out_field_b_o)
    `CHK("hrv", hv, dut.header_rewrite_valid_o)
    if (hv) `CHK("hval", e_h, dut.header_rewrite_value_o)
    `CHK("extend", ext, dut.out_pdu_extend_o)
    `CHK("transid", tid, dut.transid_check_o)
    `CHK("miss_clr", clr, dut.continuity_miss_clear_o)
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #200000 error_cnt++;
    end_of_test();
  end
  initial begin
    opt_tbl = '{`OPH_OP_CCM, `OPH_OP_LBR, `OPH_OP_LBM, `OPH_OP_LMR,
      `OPH_OP_LMM, `OPH_OP_SDM, `OPH_OP_DMR, `OPH_OP_DMM, `OPH_OP_TST, 8'h40};
    void'($urandom(98));
    repeat (4) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    rd(`OPH_ADDR_HW_CTRL, `OPH_ZERO32);
    rd(`OPH_ADDR_LOOP_SEL, 32'h00000003);
    rd(8'h40, `OPH_ZERO32);
    $display("test registers done");
    for (int r = 0; r < 16; r++) begin
      ctl = r == 0 ? 9'h000 : (r == 1 ? 9'h1ff : 9'($urandom));
      if (!ctl[1]) ctl[0] = 1'b0;
      ls = 2'($urandom); opt = 2'($urandom); qs = 16'($urandom);
      mac = {16'($urandom), 32'($urandom)};
      wr(`OPH_ADDR_HW_CTRL, {23'h0, ctl});
      wr(`OPH_ADDR_LOOP_SEL, {30'h0, ls});
      wr(`OPH_ADDR_OPTIONS, {30'h0, opt});
      wr(`OPH_ADDR_CPU_QUEUE, {16'h0, qs});
      wr(`OPH_ADDR_MAC_LOW, mac[31:0]);
      wr(`OPH_ADDR_MAC_HIGH, {16'h0, mac[47:32]});
      rd(`OPH_ADDR_MAC_HIGH, {16'h0, mac[47:32]});
      rd(`OPH_ADDR_HW_CTRL, {23'h0, ctl});
      pv = 0;
      for (int i = 0; i <= 24; i++) begin
        @(posedge mclk_i);
        frm_valid_i <= i < 24 && ($urandom % 8) != 0;
        frm_opcode_i <= opt_tbl[$urandom % 10];
        frm_tx_dir_i <= 1'($urandom); mask_i <= 8'($urandom);
        ccmv_i <= 1'($urandom);
        frm_dmac_i <= {16'($urandom), 32'($urandom)};
        frm_smac_i <= {16'($urandom), 32'($urandom)};
        #1;
        if (pv) cmp();
        else `CHK("idle", 1'b0, dut.out_valid_o)
        {pv, pop, pdir, pmsk, pcv} = {frm_valid_i, frm_opcode_i,
          frm_tx_dir_i, mask_i, ccmv_i};
        {pdm, psm, prc, ptc, prt, ptt} = {frm_dmac_i, frm_smac_i,
          rc, tc, rt, tt};
      end
      rd(`OPH_ADDR_CC_STORE, cc_rx);
      rd(`OPH_ADDR_CC_TXFCF, cc_tx);
      rd(`OPH_ADDR_STATUS, {24'h0, hcnt});
      $display("test frame round %0d done", r);
    end
    end_of_test();
  end
endmodule // oph_responder_tb
`default_nettype wire

// ==== verilog/oph_consts.vh ====
// Constants for the OAM PDU hardware responder.
`ifndef OPH_CONSTS_VH
`define OPH_CONSTS_VH
// Register offsets.
`define OPH_ADDR_HW_CTRL   8'h00
`define OPH_ADDR_LOOP_SEL  8'h04
`define OPH_ADDR_MAC_LOW   8'h08
`define OPH_ADDR_MAC_HIGH  8'h0c
`define OPH_ADDR_CPU_QUEUE 8'h10
`define OPH_ADDR_OPTIONS   8'h14
`define OPH_ADDR_CC_STORE  8'h18
`define OPH_ADDR_CC_TXFCF  8'h1c
`define OPH_ADDR_STATUS    8'h20
// Enable register bit positions.
`define OPH_BIT_LMM 8
`define OPH_BIT_LMR 7
`define OPH_BIT_LBM 6
`define OPH_BIT_LBR 5
`define OPH_BIT_DMM 4
`define OPH_BIT_DMR 3
`define OPH_BIT_SDM 2
`define OPH_BIT_CCM 1
`define OPH_BIT_CCL 0
`define OPH_HW_CTRL_W 9
// Loop select bits and option bits.
`define OPH_LSEL_LMM 1
`define OPH_LSEL_DMM 0
`define OPH_LSEL_RST 2'h3
`define OPH_OPT_LMR_EXT 0
`define OPH_OPT_CC_RSV  1
`define OPH_TST_MASK_BIT 6
// Queue field positions, four bits per queue.
`define OPH_QW 4
`define OPH_Q_LMM 0
`define OPH_Q_LMR 4
`define OPH_Q_DMM 8
`define OPH_Q_DMR 12
// Opcodes.
`define OPH_OP_CCM 8'h01
`define OPH_OP_LBR 8'h02
`define OPH_OP_LBM 8'h03
`define OPH_OP_LMR 8'h2a
`define OPH_OP_LMM 8'h2b
`define OPH_OP_SDM 8'h2d
`define OPH_OP_DMR 8'h2e
`define OPH_OP_DMM 8'h2f
`define OPH_OP_TST 8'h25
// Frame dispositions.
`define OPH_ACT_PASS  2'h0
`define OPH_ACT_LOOP  2'h1
`define OPH_ACT_CPU   2'h2
`define OPH_ACT_CHECK 2'h3
`define OPH_ZERO32 32'h00000000
`endif

// ==== verilog/oph_responder.v ====
// OAM PDU hardware responder: per-opcode handling decision and rewrite.
`timescale 1ns/1ps
`default_nettype none
`include "oph_consts.vh"
// Contract
// (RULE_01) Hardware handles only opcodes with enable set.
// (RULE_02) Enabled LMM looped or sent by select.
// (RULE_03) Looped LMM gets RxFCf and TxFCb filled.
// (RULE_04) Looped LMM swaps MACs, opcode becomes LMR.
// (RULE_05) CPU LMM goes to its queue, RxFCf updated.
// (RULE_06) Enabled LMR goes to its CPU queue.
// (RULE_07) LMR carries RxFCl; optional PDU extension.
// (RULE_08) Enabled LBM looped, MACs swapped, becomes LBR.
// (RULE_09) LBM enable also covers transmitted TST.
// (RULE_10) Enabled LBR gets transaction ID checked; the code checks only received LBR, transmitted LBR passes.
// (RULE_11) LBR enable also covers received TST.
// (RULE_12) Enabled DMM looped or sent by select.
// (RULE_13) Looped DMM gets timestamps, MACs, opcode DMR.
// (RULE_14) CPU DMM goes to its queue, RxTimeStampf set.
// (RULE_15) Enabled DMR to queue, RxTimeStampb set.
// (RULE_16) Enabled 1DM to DMR queue, RxTimeStampb set.
// (RULE_17) Enabled CCM validated before clearing miss count.
// (RULE_18) Software sets CCM loss only with CCM.
// (RULE_19) CCM loss carries RxFCl; optional reserved write.
// (RULE_20) CCM loss stores RxFCl and TxFCf for next.
// (RULE_21) Loop select: zero to CPU, one loops.
// (RULE_22) Engine MAC is 32-bit low plus 16-bit high.
// (RULE_23) Unhandled opcodes pass completely unmodified.

module oph_responder (
  // Clock and reset
  input  wire        mclk_i,
  input  wire        rst_n_i,
  // Register port
  input  wire [7:0]  reg_addr_i,
  input  wire [31:0] reg_wdata_i,
  input  wire        reg_wr_i,
  input  wire        reg_rd_i,
  output reg  [31:0] reg_rdata_o,
  // Frame descriptor from the pipeline
  // These share mclk_i with the block and need no synchroniser.
  input  wire        frm_valid_i,
  input  wire        frm_tx_dir_i,
  input  wire [7:0]  frm_opcode_i,
  input  wire [47:0] frm_dmac_i,
  input  wire [47:0] frm_smac_i,
  input  wire [7:0]  generic_opcode_forward_mask_i,
  input  wire        frm_ccm_valid_i,
  // Counters and timestamps sampled for this frame
  input  wire [31:0] perf_rx_cnt_i,
  input  wire [31:0] perf_tx_cnt_i,
  input  wire [31:0] rx_timestamp_i,
  input  wire [31:0] tx_timestamp_i,
  // Rewritten frame descriptor
  output reg         out_valid_o,
  output reg  [1:0]  out_action_o,
  output reg  [7:0]  out_opcode_o,
  output reg  [47:0] out_dmac_o,
  output reg  [47:0] out_smac_o,
  output reg  [3:0]  out_cpu_queue_o,
  output reg  [31:0] out_field_a_o,
  output reg         out_field_a_wr_o,
  output reg  [31:0] out_field_b_o,
  output reg         out_field_b_wr_o,
  output reg  [31:0] header_rewrite_value_o,
  output reg         header_rewrite_valid_o,
  output reg         out_pdu_extend_o,
  output reg         transid_check_o,
  output reg         continuity_miss_clear_o
);

  // Only bits with a meaning are stored; the rest of a word is
  // dropped on write and reads back zero. Both loop selects reset
  // to one, so requests loop until software picks the CPU path.
  // A write and a frame in one cycle: the frame sees the old value.
  reg  [8:0]  hw_ctrl_q;
  reg  [1:0]  loop_sel_q;
  reg  [31:0] mac_low_q;
  reg  [15:0] mac_high_q;
  reg  [15:0] cpu_queue_q;
  reg  [1:0]  options_q;
  reg  [31:0] cc_rxfcl_q;
  reg  [31:0] cc_txfcf_q;
  // The handled count wraps at 255. It is meant as a debug aid,
  // not as a statistic that software can rely on over time.
  reg  [7:0]  handled_cnt_q;

  // Named views of the enable, select and option bits.
  wire loss_request_hw_enable          = hw_ctrl_q[`OPH_BIT_LMM];
  wire loss_reply_hw_enable            = hw_ctrl_q[`OPH_BIT_LMR];
  wire loopback_request_hw_enable      = hw_ctrl_q[`OPH_BIT_LBM];
  wire loopback_reply_hw_enable        = hw_ctrl_q[`OPH_BIT_LBR];
  wire delay_request_hw_enable         = hw_ctrl_q[`OPH_BIT_DMM];
  wire delay_reply_hw_enable           = hw_ctrl_q[`OPH_BIT_DMR];
  wire one_way_delay_hw_enable         = hw_ctrl_q[`OPH_BIT_SDM];
  wire continuity_check_hw_enable      = hw_ctrl_q[`OPH_BIT_CCM];
  wire continuity_loss_hw_enable       = hw_ctrl_q[`OPH_BIT_CCL];
  wire loss_request_loop_select        = loop_sel_q[`OPH_LSEL_LMM];
  wire delay_request_loop_select       = loop_sel_q[`OPH_LSEL_DMM];
  wire loss_reply_pdu_extend_enable    = options_q[`OPH_OPT_LMR_EXT];
  wire continuity_reserved_update_enable = options_q[`OPH_OPT_CC_RSV];
  // The engine address is the high half above the low half.
  wire [47:0] endpoint_mac = {mac_high_q, mac_low_q}; // RULE_22
  // One nibble of queue number each for LMM, LMR, DMM and DMR; 1DM uses the DMR one.
  wire [3:0] loss_request_cpu_queue  = cpu_queue_q[`OPH_Q_LMM +: `OPH_QW];
  wire [3:0] loss_reply_cpu_queue    = cpu_queue_q[`OPH_Q_LMR +: `OPH_QW];
  wire [3:0] delay_request_cpu_queue = cpu_queue_q[`OPH_Q_DMM +: `OPH_QW];
  wire [3:0] delay_reply_cpu_queue   = cpu_queue_q[`OPH_Q_DMR +: `OPH_QW];
  // Test frames are handled only when the forward mask selects them.
  wire tst_sel = generic_opcode_forward_mask_i[`OPH_TST_MASK_BIT];

  // Combinational decision for the current frame.
  reg [1:0]  act_d;
  reg [7:0]  op_d;
  reg [47:0] dmac_d;
  reg [47:0] smac_d;
  reg [3:0]  queue_d;
  reg [31:0] fa_d;
  reg        fa_wr_d;
  reg [31:0] fb_d;
  reg        fb_wr_d;
  reg [31:0] rew_d;
  reg        rew_vld_d;
  reg        ext_d;
  reg        tid_d;
  reg        miss_clr_d;
  reg        cc_store_d;

  always @* begin
    // Defaults leave the frame untouched.
    act_d      = `OPH_ACT_PASS; // RULE_23
    op_d       = frm_opcode_i;
    dmac_d     = frm_dmac_i;
    smac_d     = frm_smac_i;
    queue_d    = 4'h0;
    fa_d       = `OPH_ZERO32;
    fa_wr_d    = 1'b0;
    fb_d       = `OPH_ZERO32;
    fb_wr_d    = 1'b0;
    rew_d      = `OPH_ZERO32;
    rew_vld_d  = 1'b0;
    ext_d      = 1'b0;
    tid_d      = 1'b0;
    miss_clr_d = 1'b0;
    cc_store_d = 1'b0;
    // Each branch tests an enable bit first; TST uses the loopback ones. With the bit clear
    // the defaults stand and the frame leaves exactly as it came, so
    // an unhandled opcode can never pick up a stray rewrite.
    case (frm_opcode_i) // RULE_01

      // Loss request: counters first, then loop or redirect.
      `OPH_OP_LMM: begin
        if (loss_request_hw_enable) begin // RULE_02
          fa_d    = perf_rx_cnt_i;
          fa_wr_d = 1'b1;
          if (loss_request_loop_select) begin // RULE_21
            act_d   = `OPH_ACT_LOOP;
            fb_d    = perf_tx_cnt_i; // RULE_03
            fb_wr_d = 1'b1;
            dmac_d  = frm_smac_i; // RULE_04
            smac_d  = endpoint_mac;
            op_d    = `OPH_OP_LMR;
          end else begin
            act_d   = `OPH_ACT_CPU; // RULE_05
            queue_d = loss_request_cpu_queue;
          end
        end
      end

      // Loss reply: always redirected, receive count in header.
      `OPH_OP_LMR: begin
        if (loss_reply_hw_enable) begin
          act_d     = `OPH_ACT_CPU; // RULE_06
          queue_d   = loss_reply_cpu_queue;
          rew_d     = perf_rx_cnt_i; // RULE_07
          rew_vld_d = 1'b1;
          ext_d     = loss_reply_pdu_extend_enable;
        end
      end

      // Loopback request: addresses swapped, no counters.
      `OPH_OP_LBM: begin
        if (loopback_request_hw_enable) begin
          act_d  = `OPH_ACT_LOOP; // RULE_08
          dmac_d = frm_smac_i;
          smac_d = endpoint_mac;
          op_d   = `OPH_OP_LBR;
        end
      end

      // Loopback reply: only received replies carry an id.
      `OPH_OP_LBR: begin
        if (loopback_reply_hw_enable && !frm_tx_dir_i) begin
          act_d = `OPH_ACT_CHECK; // RULE_10
          tid_d = 1'b1;
        end
      end

      // Test frames use the loopback enables, one per direction.
      `OPH_OP_TST: begin
        if (tst_sel && frm_tx_dir_i && loopback_request_hw_enable) begin
          act_d = `OPH_ACT_CHECK; // RULE_09
        end else if (tst_sel && !frm_tx_dir_i &&
                     loopback_reply_hw_enable) begin
          act_d = `OPH_ACT_CHECK; // RULE_11
          tid_d = 1'b1;
        end
      end

      // Delay request: timestamps first, then loop or redirect.
      `OPH_OP_DMM: begin
        if (delay_request_hw_enable) begin // RULE_12
          fa_d    = rx_timestamp_i;
          fa_wr_d = 1'b1;
          if (delay_request_loop_select) begin // RULE_21
            act_d   = `OPH_ACT_LOOP; // RULE_13
            fb_d    = tx_timestamp_i;
            fb_wr_d = 1'b1;
            dmac_d  = frm_smac_i;
            smac_d  = endpoint_mac;
            op_d    = `OPH_OP_DMR;
          end else begin
            act_d   = `OPH_ACT_CPU; // RULE_14
            queue_d = delay_request_cpu_queue;
          end
        end
      end

      // Delay reply: receive timestamp, then its queue.
      `OPH_OP_DMR: begin
        if (delay_reply_hw_enable) begin
          act_d   = `OPH_ACT_CPU; // RULE_15
          queue_d = delay_reply_cpu_queue;
          fb_d    = rx_timestamp_i;
          fb_wr_d = 1'b1;
        end
      end

      // One-way delay shares the delay reply queue.
      `OPH_OP_SDM: begin
        if (one_way_delay_hw_enable) begin
          act_d   = `OPH_ACT_CPU; // RULE_16
          queue_d = delay_reply_cpu_queue;
          fb_d    = rx_timestamp_i;
          fb_wr_d = 1'b1;
        end
      end

      // Continuity check: the clear follows validation only.
      `OPH_OP_CCM: begin
        if (continuity_check_hw_enable) begin
          act_d      = `OPH_ACT_CHECK;
          miss_clr_d = frm_ccm_valid_i; // RULE_17
          // The loss part is gated by the check enable, so a stray loss
          // enable alone never alters a frame.
          if (continuity_loss_hw_enable && frm_ccm_valid_i) begin // RULE_18
            rew_d      = perf_rx_cnt_i; // RULE_19
            rew_vld_d  = 1'b1;
            fa_d       = perf_rx_cnt_i;
            fa_wr_d    = continuity_reserved_update_enable;
            cc_store_d = 1'b1; // RULE_20
          end
        end
      end

      // Any other opcode passes untouched.
      default: begin
        act_d = `OPH_ACT_PASS; // RULE_23
      end
    endcase
  end

  // Registered frame outputs, one cycle after the descriptor.
  // Data fields follow the decision even on idle cycles. Only the
  // strobes are gated by the valid pulse, so the pipeline must look
  // at a strobe before it uses the field beside it.
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      out_valid_o             <= 1'b0;
      out_action_o            <= `OPH_ACT_PASS;
      out_opcode_o            <= 8'h00;
      out_dmac_o              <= 48'h000000000000;
      out_smac_o              <= 48'h000000000000;
      out_cpu_queue_o         <= 4'h0;
      out_field_a_o           <= `OPH_ZERO32;
      out_field_a_wr_o        <= 1'b0;
      out_field_b_o           <= `OPH_ZERO32;
      out_field_b_wr_o        <= 1'b0;
      header_rewrite_value_o  <= `OPH_ZERO32;
      header_rewrite_valid_o  <= 1'b0;
      out_pdu_extend_o        <= 1'b0;
      transid_check_o         <= 1'b0;
      continuity_miss_clear_o <= 1'b0;
      cc_rxfcl_q              <= `OPH_ZERO32;
      cc_txfcf_q              <= `OPH_ZERO32;
      handled_cnt_q           <= 8'h00;
    end else begin
      out_valid_o             <= frm_valid_i;
      out_action_o            <= act_d;
      out_opcode_o            <= op_d;
      out_dmac_o              <= dmac_d;
      out_smac_o              <= smac_d;
      out_cpu_queue_o         <= queue_d;
      out_field_a_o           <= fa_d;
      out_field_a_wr_o        <= frm_valid_i & fa_wr_d;
      out_field_b_o           <= fb_d;
      out_field_b_wr_o        <= frm_valid_i & fb_wr_d;
      header_rewrite_value_o  <= rew_d;
      header_rewrite_valid_o  <= frm_valid_i & rew_vld_d;
      out_pdu_extend_o        <= frm_valid_i & ext_d;
      transid_check_o         <= frm_valid_i & tid_d;
      continuity_miss_clear_o <= frm_valid_i & miss_clr_d;
      // The stored pair feeds the next transmitted continuity frame.
      if (frm_valid_i && cc_store_d) begin
        cc_rxfcl_q <= perf_rx_cnt_i; // RULE_20
        cc_txfcf_q <= perf_tx_cnt_i;
      end
      // Any valid frame given hardware handling counts once.
      if (frm_valid_i && act_d != `OPH_ACT_PASS) begin
        handled_cnt_q <= handled_cnt_q + 8'h01;
      end
    end
  end

  // Register writes.
  // Unmapped and read-only offsets ignore writes.
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      hw_ctrl_q   <= 9'h000;
      loop_sel_q  <= `OPH_LSEL_RST;
      mac_low_q   <= `OPH_ZERO32;
      mac_high_q  <= 16'h0000;
      cpu_queue_q <= 16'h0000;
      options_q   <= 2'h0;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `OPH_ADDR_HW_CTRL:   hw_ctrl_q   <= reg_wdata_i[8:0];
        `OPH_ADDR_LOOP_SEL:  loop_sel_q  <= reg_wdata_i[1:0];
        `OPH_ADDR_MAC_LOW:   mac_low_q   <= reg_wdata_i;
        `OPH_ADDR_MAC_HIGH:  mac_high_q  <= reg_wdata_i[15:0];
        `OPH_ADDR_CPU_QUEUE: cpu_queue_q <= reg_wdata_i[15:0];
        `OPH_ADDR_OPTIONS:   options_q   <= reg_wdata_i[1:0];
        default: begin
        end
      endcase
    end
  end

  // Register reads; unmapped addresses read zero.
  // The data stand only in the cycle after the strobe. A late
  // sample sees zero rather than stale data.
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= `OPH_ZERO32;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `OPH_ADDR_HW_CTRL:   reg_rdata_o <= {23'h000000, hw_ctrl_q};
        `OPH_ADDR_LOOP_SEL:  reg_rdata_o <= {30'h00000000, loop_sel_q};
        `OPH_ADDR_MAC_LOW:   reg_rdata_o <= mac_low_q;
        `OPH_ADDR_MAC_HIGH:  reg_rdata_o <= {16'h0000, mac_high_q};
        `OPH_ADDR_CPU_QUEUE: reg_rdata_o <= {16'h0000, cpu_queue_q};
        `OPH_ADDR_OPTIONS:   reg_rdata_o <= {30'h00000000, options_q};
        `OPH_ADDR_CC_STORE:  reg_rdata_o <= cc_rxfcl_q;
        `OPH_ADDR_CC_TXFCF:  reg_rdata_o <= cc_txfcf_q;
        `OPH_ADDR_STATUS:    reg_rdata_o <= {24'h000000, handled_cnt_q};
        default:             reg_rdata_o <= `OPH_ZERO32;
      endcase
    end else begin
      reg_rdata_o <= `OPH_ZERO32;
    end
  end

endmodule // oph_responder

`default_nettype wire
